/* File: core/charger_params.svh */
// Offsets, field positions, reset values and timing counts of the bank.
`ifndef CHARGER_PARAMS_SVH
`define CHARGER_PARAMS_SVH

`define REG_CTL3_ADDR 8'h07
`define REG_TZONE_ADDR 8'h08
`define REG_RSVD_ADDR 8'h09
`define REG_OPTLIM_ADDR 8'h0a
`define REG_STAT1_ADDR 8'h0b

`define CTL3_RESET 8'h00
`define TZONE_RESET 8'h0d
`define CTL3_FIXED_BITS 4'h2

`define LIGHT_LOAD_BIT 7
`define KICK_BIT 6
`define TOPOFF_HI 5
`define TOPOFF_LO 4
`define WARM_V_HI 4
`define WARM_V_LO 3
`define WARM_I_BIT 2
`define COOL_I_HI 1
`define COOL_I_LO 0
`define WD_FLAG_BIT 3

`define TOPOFF_RESET 2'h0
`define WARM_V_RESET 2'h1
`define WARM_I_RESET 1'h1
`define COOL_I_RESET 2'h1

`define TOPOFF_MIN_STEP 6'h0f
`define WARM_V_LOW_MV 14'h1f40
`define WARM_V_HIGH_MV 14'h206c
`define PCT_20 7'h14
`define PCT_40 7'h28
`define PCT_100 7'h64
`define OPT_LIMIT_MAX 5'h1c

`define CLK_HZ 64'd250000000
`define WD_BASE_S 64'd40
`define WD_PERIOD_RESET 2'h1

`define TARGET_ADDR_DEFAULT 7'h55

`endif

/* File: core/charger_pkg.sv */
// Types shared by the charger register bank and its serial target port.
package charger_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_PTR = 3'b010,
    PH_WDATA = 3'b011,
    PH_RDATA = 3'b100,
    PH_ACK = 3'b101,
    PH_MACK = 3'b110
  } port_phase_type;

  typedef struct packed {
    port_phase_type phase;
    port_phase_type after;
    logic [7:0] shift;
    logic [3:0] count;
    logic [7:0] ptr;
    logic drive;
    logic sclPrev;
    logic sdaPrev;
    reg_write_type wr;
  } port_state_type;

  typedef struct packed {
    logic lightLoadOff;
    logic kick;
    logic [1:0] topoffSel;
    logic [1:0] warmVoltSel;
    logic warmCurSel;
    logic [1:0] coolCurSel;
    logic [4:0] optCode;
    logic [35:0] wdCount;
    logic wdFlag;
    logic wdExpire;
    logic [5:0] topoffMin;
    logic [13:0] warmMv;
    logic [6:0] warmPct;
    logic [6:0] coolPct;
  } bank_state_type;

endpackage

/* File: core/serial_target_port.sv */
// Two-wire serial target that turns host transfers into register accesses.
`timescale 1ns/1ps
`include "charger_params.svh"
module serial_target_port #(
  parameter logic [6:0] TargetAddr = `TARGET_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdData,
  output charger_pkg::reg_write_type regWrite
);
  import charger_pkg::*;

  port_state_type s_q;
  port_state_type s_d;
  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic sclFall;

  assign startSeen = sclIn && s_q.sclPrev && s_q.sdaPrev && !sdaIn;
  assign stopSeen = sclIn && s_q.sclPrev && !s_q.sdaPrev && sdaIn;
  assign sclRise = !s_q.sclPrev && sclIn;
  assign sclFall = s_q.sclPrev && !sclIn;

  assign sdaOut = 1'b0;
  assign sdaOe = s_q.drive;
  assign rdAddr = s_q.ptr;
  assign regWrite = s_q.wr;

  always_comb begin
    s_d = s_q;
    s_d.sclPrev = sclIn;
    s_d.sdaPrev = sdaIn;
    s_d.wr.valid = 1'b0;
    if (startSeen) begin
      s_d.phase = PH_ADDR;
      s_d.count = 4'h0;
      s_d.drive = 1'b0;
    end else if (stopSeen) begin
      s_d.phase = PH_IDLE;
      s_d.drive = 1'b0;
    end else if (sclRise) begin
      case (s_q.phase)
        PH_ADDR, PH_PTR, PH_WDATA: begin
          s_d.shift = {s_q.shift[6:0], sdaIn};
          s_d.count = s_q.count + 4'h1;
        end
        PH_MACK: begin
          // A not-acknowledge from the host ends the read burst.
          s_d.after = sdaIn ? PH_IDLE : PH_RDATA;
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      case (s_q.phase)
        PH_ADDR: begin
          if (s_q.count == 4'h8) begin
            s_d.count = 4'h0;
            if (s_q.shift[7:1] == TargetAddr) begin
              s_d.drive = 1'b1;
              s_d.phase = PH_ACK;
              s_d.after = s_q.shift[0] ? PH_RDATA : PH_PTR;
            end else begin
              s_d.phase = PH_IDLE;
            end
          end
        end
        PH_PTR: begin
          if (s_q.count == 4'h8) begin
            s_d.count = 4'h0;
            s_d.ptr = s_q.shift;
            s_d.drive = 1'b1;
            s_d.phase = PH_ACK;
            s_d.after = PH_WDATA;
          end
        end
        PH_WDATA: begin
          if (s_q.count == 4'h8) begin
            s_d.count = 4'h0;
            s_d.wr.valid = 1'b1;
            s_d.wr.addr = s_q.ptr;
            s_d.wr.data = s_q.shift;
            s_d.ptr = s_q.ptr + 8'h01;
            s_d.drive = 1'b1;
            s_d.phase = PH_ACK;
            s_d.after = PH_WDATA;
          end
        end
        PH_RDATA: begin
          if (s_q.count == 4'h8) begin
            s_d.count = 4'h0;
            s_d.drive = 1'b0;
            s_d.phase = PH_MACK;
          end else begin
            s_d.drive = !s_q.shift[7];
            s_d.shift = {s_q.shift[6:0], 1'b0};
            s_d.count = s_q.count + 4'h1;
          end
        end
        PH_ACK, PH_MACK: begin
          s_d.phase = s_q.after;
          s_d.drive = 1'b0;
          if (s_q.after == PH_RDATA) begin
            s_d.drive = !rdData[7];
            s_d.shift = {rdData[6:0], 1'b0};
            s_d.count = 4'h1;
            s_d.ptr = s_q.ptr + 8'h01;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{phase: PH_IDLE, after: PH_IDLE, shift: 8'h00, count: 4'h0,
               ptr: 8'h00, drive: 1'b0, sclPrev: 1'b1, sdaPrev: 1'b1,
               wr: '0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule // serial_target_port

/* File: core/charger_control_register_bank.sv */
// Charger control and temperature-zone register bank with host watchdog.
//
// Contract
// - Light-load bit set blocks pulse-frequency mode.
// - Kick bit restarts watchdog, then self-clears.
// - Top-off field selects off, 15, 30, 45 minutes.
// - Control bits 3,2,0 read 0; bit 1 reads 1.
// - Warm voltage: suspend, 8.0V, 8.3V, unchanged.
// - Warm current bit: 40 or 100 percent.
// - Cool current: suspend, 20, 40, 100 percent.
// - Zone and top-off fields restore on watchdog expiry.
// - Control resets 00h; zone upper bits read 0.
// - Reserved register reads zero always.
// - Optimizer limit code reported, upper bits zero.
// - Watchdog period: off, 40, 80, 160 seconds.
// - Expiry sets a read-only watchdog flag.
`timescale 1ns/1ps
`include "charger_params.svh"
module charger_control_register_bank #(
  parameter logic [35:0] WdBaseCycles = 36'(`WD_BASE_S * `CLK_HZ),
  parameter logic [6:0] TargetAddr = `TARGET_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic regResetReq,
  input wire logic [1:0] watchdogPeriodSel,
  input wire logic optimizerEnabled,
  input wire logic [4:0] optimizerLimitIn,
  input wire logic [7:0] chargerStatusIn,
  output logic lightLoadModeAllowed,
  output logic [1:0] topoffDurationSel,
  output logic [5:0] topoffMinutes,
  output logic warmZoneSuspend,
  output logic warmZoneKeepNormal,
  output logic [13:0] warmZoneVoltageMv,
  output logic [6:0] warmZoneCurrentPct,
  output logic coolZoneSuspend,
  output logic [6:0] coolZoneCurrentPct,
  output logic watchdogExpiredFlag,
  output logic watchdogExpiryPulse
);
  import charger_pkg::*;

  bank_state_type s_q;
  bank_state_type s_d;
  reg_write_type regWrite;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  logic [35:0] wdLimit;
  logic wdEnabled;
  logic wdTimeout;
  logic ctlWrite;
  logic zoneWrite;

  serial_target_port #(
    .TargetAddr(TargetAddr)
  ) u_port (
    .sys_clk(sys_clk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .regWrite(regWrite)
  );

  // Read data is decoded from live state; the status register also passes chargerStatusIn bits through.
  always_comb begin
    if (rdAddr == `REG_CTL3_ADDR) begin
      rdData = {s_q.lightLoadOff, s_q.kick, s_q.topoffSel,
                `CTL3_FIXED_BITS};
    end else if (rdAddr == `REG_TZONE_ADDR) begin
      rdData = {3'h0, s_q.warmVoltSel, s_q.warmCurSel,
                s_q.coolCurSel};
    end else if (rdAddr == `REG_RSVD_ADDR) begin
      rdData = 8'h00;
    end else if (rdAddr == `REG_OPTLIM_ADDR) begin
      rdData = {3'h0, s_q.optCode};
    end else if (rdAddr == `REG_STAT1_ADDR) begin
      rdData = {1'b0, chargerStatusIn[6:4], s_q.wdFlag,
                chargerStatusIn[2:0]};
    end else begin
      rdData = 8'h00;
    end
  end

  // Period doubles per step of the selector.
  always_comb begin
    case (watchdogPeriodSel)
      2'h1: wdLimit = WdBaseCycles;
      2'h2: wdLimit = {WdBaseCycles[34:0], 1'b0};
      2'h3: wdLimit = {WdBaseCycles[33:0], 2'h0};
      default: wdLimit = WdBaseCycles;
    endcase
  end

  assign wdEnabled = watchdogPeriodSel != 2'h0;
  assign wdTimeout = wdEnabled && (s_q.wdCount >= wdLimit - 36'h1);
  assign ctlWrite = regWrite.valid && regWrite.addr == `REG_CTL3_ADDR;
  assign zoneWrite = regWrite.valid && regWrite.addr == `REG_TZONE_ADDR;

  always_comb begin
    s_d = s_q;
    s_d.wdExpire = 1'b0;
    // Only the writable fields take host data; fixed bits never store.
    if (ctlWrite) begin
      s_d.lightLoadOff = regWrite.data[`LIGHT_LOAD_BIT];
      s_d.kick = regWrite.data[`KICK_BIT];
      s_d.topoffSel = regWrite.data[`TOPOFF_HI:`TOPOFF_LO];
    end
    if (zoneWrite) begin
      s_d.warmVoltSel = regWrite.data[`WARM_V_HI:`WARM_V_LO];
      s_d.warmCurSel = regWrite.data[`WARM_I_BIT];
      s_d.coolCurSel = regWrite.data[`COOL_I_HI:`COOL_I_LO];
    end
    // A stored kick restarts the timer and then clears itself.
    if (s_q.kick) begin
      s_d.kick = 1'b0;
      s_d.wdCount = 36'h0;
      s_d.wdFlag = 1'b0;
    end else if (!wdEnabled) begin
      s_d.wdCount = 36'h0;
    end else if (wdTimeout) begin
      s_d.wdCount = 36'h0;
      s_d.wdExpire = 1'b1;
    end else begin
      s_d.wdCount = s_q.wdCount + 36'h1;
    end
    // Expiry restores the watchdog-reset fields but keeps light-load.
    if (s_d.wdExpire) begin
      s_d.wdFlag = 1'b1;
      s_d.kick = 1'b0;
      s_d.topoffSel = `TOPOFF_RESET;
      s_d.warmVoltSel = `WARM_V_RESET;
      s_d.warmCurSel = `WARM_I_RESET;
      s_d.coolCurSel = `COOL_I_RESET;
    end
    // Register reset restores every writable field; the flag is kept.
    if (regResetReq) begin
      s_d.lightLoadOff = 1'(`CTL3_RESET >> `LIGHT_LOAD_BIT);
      s_d.kick = 1'b0;
      s_d.topoffSel = `TOPOFF_RESET;
      s_d.warmVoltSel = `WARM_V_RESET;
      s_d.warmCurSel = `WARM_I_RESET;
      s_d.coolCurSel = `COOL_I_RESET;
      s_d.wdCount = 36'h0;
    end
    // The reported limit follows the optimizer only while it runs.
    if (optimizerEnabled) begin
      s_d.optCode = (optimizerLimitIn > `OPT_LIMIT_MAX) ?
                    `OPT_LIMIT_MAX : optimizerLimitIn;
    end
    case (s_d.topoffSel)
      2'h1: s_d.topoffMin = `TOPOFF_MIN_STEP;
      2'h2: s_d.topoffMin = 6'(`TOPOFF_MIN_STEP * 2);
      2'h3: s_d.topoffMin = 6'(`TOPOFF_MIN_STEP * 3);
      default: s_d.topoffMin = 6'h00;
    endcase
    case (s_d.warmVoltSel)
      2'h1: s_d.warmMv = `WARM_V_LOW_MV;
      2'h2: s_d.warmMv = `WARM_V_HIGH_MV;
      default: s_d.warmMv = 14'h0000;
    endcase
    s_d.warmPct = s_d.warmCurSel ? `PCT_100 : `PCT_40;
    case (s_d.coolCurSel)
      2'h1: s_d.coolPct = `PCT_20;
      2'h2: s_d.coolPct = `PCT_40;
      2'h3: s_d.coolPct = `PCT_100;
      default: s_d.coolPct = 7'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{lightLoadOff: 1'b0, kick: 1'b0, topoffSel: `TOPOFF_RESET,
               warmVoltSel: `WARM_V_RESET, warmCurSel: `WARM_I_RESET,
               coolCurSel: `COOL_I_RESET, optCode: 5'h00,
               wdCount: 36'h0, wdFlag: 1'b0, wdExpire: 1'b0,
               topoffMin: 6'h00, warmMv: `WARM_V_LOW_MV,
               warmPct: `PCT_100, coolPct: `PCT_20};
    end else begin
      s_q <= s_d;
    end
  end

  assign lightLoadModeAllowed = !s_q.lightLoadOff;
  assign topoffDurationSel = s_q.topoffSel;
  assign topoffMinutes = s_q.topoffMin;
  assign warmZoneSuspend = s_q.warmVoltSel == 2'h0;
  assign warmZoneKeepNormal = s_q.warmVoltSel == 2'h3;
  assign warmZoneVoltageMv = s_q.warmMv;
  assign warmZoneCurrentPct = s_q.warmPct;
  assign coolZoneSuspend = s_q.coolCurSel == 2'h0;
  assign coolZoneCurrentPct = s_q.coolPct;
  assign watchdogExpiredFlag = s_q.wdFlag;
  assign watchdogExpiryPulse = s_q.wdExpire;

endmodule // charger_control_register_bank

/* File: test/charger_bank_properties.sv */
// Concurrent checks on the charger register bank ports.
`timescale 1ns/1ps
module charger_bank_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaOe,
  input wire logic regResetReq,
  input wire logic [1:0] watchdogPeriodSel,
  input wire logic lightLoadModeAllowed,
  input wire logic [1:0] topoffDurationSel,
  input wire logic [5:0] topoffMinutes,
  input wire logic warmZoneSuspend,
  input wire logic warmZoneKeepNormal,
  input wire logic [13:0] warmZoneVoltageMv,
  input wire logic [6:0] warmZoneCurrentPct,
  input wire logic coolZoneSuspend,
  input wire logic [6:0] coolZoneCurrentPct,
  input wire logic watchdogExpiredFlag,
  input wire logic watchdogExpiryPulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence restored_s;
    topoffDurationSel == 2'h0 && !warmZoneSuspend && !coolZoneSuspend;
  endsequence
  sequence defaults_s;
    topoffMinutes == 6'h0 && warmZoneVoltageMv == 14'h1f40 &&
      coolZoneCurrentPct == 7'h14 && warmZoneCurrentPct == 7'h64;
  endsequence
  chk_topoff_decode: assert property (
    topoffMinutes == 6'hf * topoffDurationSel)
    else $error("top-off minutes do not follow the field");
  chk_warm_volt_set: assert property (
    !warmZoneSuspend && !warmZoneKeepNormal |->
      warmZoneVoltageMv inside {14'h1f40, 14'h206c})
    else $error("warm voltage not 8.0V or 8.3V");
  chk_warm_volt_off: assert property (
    warmZoneSuspend || warmZoneKeepNormal |-> warmZoneVoltageMv == 14'h0)
    else $error("warm voltage reported while not set");
  chk_warm_pct_legal: assert property (
    warmZoneCurrentPct inside {7'h28, 7'h64})
    else $error("warm current scale out of range");
  chk_cool_suspend: assert property (
    coolZoneSuspend |-> coolZoneCurrentPct == 7'h0)
    else $error("cool current nonzero while suspended");
  chk_cool_pct_legal: assert property (
    !coolZoneSuspend |-> coolZoneCurrentPct inside {7'h14, 7'h28, 7'h64})
    else $error("cool current scale out of range");
  chk_reg_reset: assert property (
    regResetReq |=> restored_s and (lightLoadModeAllowed ##1 defaults_s))
    else $error("register reset did not restore defaults");
  chk_expiry_restore: assert property (
    watchdogExpiryPulse |-> restored_s ##1 defaults_s)
    else $error("expiry did not restore zone and top-off fields");
  chk_flag_cause: assert property (
    $rose(watchdogExpiredFlag) |-> watchdogExpiryPulse)
    else $error("expiry flag set without expiry");
  chk_pulse_single: assert property (
    watchdogExpiryPulse |=> !watchdogExpiryPulse)
    else $error("expiry pulse longer than one cycle");
  chk_wd_off: assert property (
    watchdogPeriodSel == 2'h0 [*3] |-> !watchdogExpiryPulse)
    else $error("expiry while watchdog disabled");
  chk_ack_stands: assert property (
    !$stable(sdaOe) |-> !sclIn)
    else $error("data line changed while serial clock high");
endmodule // charger_bank_properties

bind charger_control_register_bank charger_bank_properties chk (
  .sys_clk, .rst, .sclIn, .sdaOe, .regResetReq, .watchdogPeriodSel,
  .lightLoadModeAllowed, .topoffDurationSel, .topoffMinutes,
  .warmZoneSuspend, .warmZoneKeepNormal, .warmZoneVoltageMv,
  .warmZoneCurrentPct, .coolZoneSuspend, .coolZoneCurrentPct,
  .watchdogExpiredFlag, .watchdogExpiryPulse
);

/* File: test/host_model.sv */
// Host controller model driving the serial clock and pulling data low.
`timescale 1ns/1ps
module host_model #(
  parameter logic [6:0] Addr = 7'h55
) (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // One bit: drive b (1 releases the line) and sample the wire mid-high.
  task automatic bt(input logic b, output logic r);
    sdaLow = ~b;
    hc(4);
    scl = 1'b1;
    hc(4);
    r = sda;
    hc(4);
    scl = 1'b0;
    hc(4);
  endtask
  // Serves as first and as repeated start.
  task automatic start();
    sdaLow = 1'b0;
    hc(4);
    scl = 1'b1;
    hc(8);
    sdaLow = 1'b1;
    hc(8);
    scl = 1'b0;
    hc(4);
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(8);
    sdaLow = 1'b0;
    hc(8);
  endtask
  // Ninth bit is released, so a read byte ends with a host NACK.
  task automatic by(input logic [7:0] d, output logic [7:0] q,
      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(1'b1, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, d,
      output logic ok);
    logic [7:0] q;
    logic k;
    start();
    by({dev, 1'b0}, q, ok);
    if (ok) begin
      by(a, q, k);
      by(d, q, k);
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic k;
    start();
    by({Addr, 1'b0}, q, k);
    by(a, q, k);
    start();
    by({Addr, 1'b1}, q, k);
    by(8'hff, q, k);
    stop();
  endtask
endmodule // host_model

/* File: test/charger_control_register_bank_tb.sv */
// Self-checking bench for the charger register bank over the serial port.
`timescale 1ns/1ps
module charger_control_register_bank_tb;
  localparam logic [6:0] Addr = 7'h55; // Arbitrary target address.
  localparam int Lim = 1500;
  localparam logic [15:0] MvTab [4] = '{16'h0, 16'h1f40, 16'h206c, 16'h0};
  localparam logic [15:0] PctTab [4] = '{16'h0, 16'h14, 16'h28, 16'h64};
  logic sys_clk, rst, sclIn, sdaIn, sdaOut, sdaOe, hostLow, ok;
  logic regResetReq, optimizerEnabled, lightLoadModeAllowed;
  logic warmZoneSuspend, warmZoneKeepNormal, coolZoneSuspend;
  logic watchdogExpiredFlag, watchdogExpiryPulse;
  logic [1:0] watchdogPeriodSel, topoffDurationSel;
  logic [4:0] optimizerLimitIn;
  logic [7:0] chargerStatusIn, q;
  logic [5:0] topoffMinutes;
  logic [13:0] warmZoneVoltageMv;
  logic [6:0] warmZoneCurrentPct, coolZoneCurrentPct;
  int err_count = 0;
  int check_count = 0;
  int n;
  // The data line has a pull-up; either party may pull it low.
  assign sdaIn = !hostLow && (!sdaOe || sdaOut);
  charger_control_register_bank #(
    .WdBaseCycles(36'(Lim)), .TargetAddr(Addr)
  ) DUT (
    .sys_clk, .rst, .sclIn, .sdaIn, .sdaOut, .sdaOe, .regResetReq,
    .watchdogPeriodSel, .optimizerEnabled, .optimizerLimitIn,
    .chargerStatusIn, .lightLoadModeAllowed, .topoffDurationSel,
    .topoffMinutes, .warmZoneSuspend, .warmZoneKeepNormal,
    .warmZoneVoltageMv, .warmZoneCurrentPct, .coolZoneSuspend,
    .coolZoneCurrentPct, .watchdogExpiredFlag, .watchdogExpiryPulse
  );
  host_model #(.Addr(Addr)) host (
    .sys_clk, .sda(sdaIn), .scl(sclIn), .sdaLow(hostLow)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, exp);
    host.rd(a, q);
    cmp(16'(q), 16'(exp), "register read");
  endtask
  task automatic wr(input logic [7:0] a, d);
    host.wr(Addr, a, d, ok);
  endtask
  task automatic waitPulse(output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (watchdogExpiryPulse !== 1'b1 && c < 8 * Lim);
  endtask
  initial begin
    #300000;
    err_count++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    regResetReq = 1'b0;
    watchdogPeriodSel = 2'h0;
    optimizerEnabled = 1'b0;
    optimizerLimitIn = 5'h0;
    chargerStatusIn = 8'h0;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    rdChk(8'h07, 8'h02);
    rdChk(8'h08, 8'h0d);
    rdChk(8'h09, 8'h00);
    cmp(16'(lightLoadModeAllowed), 16'h1, "light load");
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h07, {k[0], 1'b1, k[1:0], 4'hd});
      rdChk(8'h07, {k[0], 1'b0, k[1:0], 4'h2});
      cmp(16'(lightLoadModeAllowed), 16'(!k[0]), "light load");
      cmp(16'(topoffDurationSel), 16'(k), "top-off sel");
      cmp(16'(topoffMinutes), 16'(k * 15), "top-off");
    end
    $display("test control register done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h08, {3'h7, k[1:0], k[0], k[1:0]});
      rdChk(8'h08, {3'h0, k[1:0], k[0], k[1:0]});
      cmp(16'({warmZoneSuspend, warmZoneKeepNormal, coolZoneSuspend}),
        16'({k == 0, k == 3, k == 0}), "suspend");
      cmp(16'(warmZoneVoltageMv), MvTab[k], "warm mv");
      cmp(16'(warmZoneCurrentPct), k[0] ? 16'h64 : 16'h28, "warm");
      cmp(16'(coolZoneCurrentPct), PctTab[k], "cool");
    end
    $display("test zone register done");
    wr(8'h09, 8'hff);
    rdChk(8'h09, 8'h00);
    optimizerEnabled = 1'b1;
    optimizerLimitIn = 5'h1f;
    rdChk(8'h0a, 8'h1c);
    optimizerLimitIn = 5'h0a;
    rdChk(8'h0a, 8'h0a);
    optimizerEnabled = 1'b0;
    optimizerLimitIn = 5'h03;
    wr(8'h0a, 8'hff);
    rdChk(8'h0a, 8'h0a);
    host.wr(7'h2a, 8'h07, 8'h80, ok);
    cmp(16'(ok), 16'h0, "foreign address acked");
    rdChk(8'h07, 8'hb2);
    $display("test read-only registers done");
    regResetReq = 1'b1;
    @(negedge sys_clk) regResetReq = 1'b0;
    rdChk(8'h07, 8'h02);
    rdChk(8'h08, 8'h0d);
    $display("test register reset done");
    wr(8'h07, 8'h90);
    wr(8'h08, 8'h00);
    chargerStatusIn = 8'h77;
    watchdogPeriodSel = 2'h1;
    waitPulse(n);
    cmp(16'(watchdogExpiredFlag), 16'h1, "flag");
    rdChk(8'h07, 8'h82);
    rdChk(8'h08, 8'h0d);
    rdChk(8'h0b, 8'h7f);
    for (int s = 1; s < 4; s++) begin
      watchdogPeriodSel = s[1:0];
      waitPulse(n);
      waitPulse(n);
      cmp(16'(n), 16'(Lim << (s - 1)), "period");
    end
    // A kick just after an expiry must push the next one a full period out.
    watchdogPeriodSel = 2'h1;
    waitPulse(n);
    wr(8'h07, 8'h40);
    cmp(16'(watchdogExpiredFlag), 16'h0, "flag");
    waitPulse(n);
    cmp(16'(n > Lim - 100), 16'h1, "kick restart");
    watchdogPeriodSel = 2'h0;
    wr(8'h07, 8'h40);
    rdChk(8'h0b, 8'h77);
    $display("test watchdog done");
    report_and_stop();
  end
endmodule // charger_control_register_bank_tb
